// file: src/xbus_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the external bus pin control.
// Assumes: One oscillator period per pclk cycle.
// Notes: Special function register numbers are word indices, four bytes apart on APB; bus access offsets are bytes.
`ifndef XBUS_DEFS_SVH
`define XBUS_DEFS_SVH
`define AUX_CONTROL_IDX 12'h08e
`define PORT0_IDX 12'h080
`define PORT1_IDX 12'h090
`define PORT2_IDX 12'h0a0
`define PORT3_IDX 12'h0b0
`define AUX_CONTROL_OFF (`AUX_CONTROL_IDX * 12'd4)
`define PORT0_OFF (`PORT0_IDX * 12'd4)
`define PORT1_OFF (`PORT1_IDX * 12'd4)
`define PORT2_OFF (`PORT2_IDX * 12'd4)
`define PORT3_OFF (`PORT3_IDX * 12'd4)
`define BUSREQ_OFF 12'h100
`define BUSADDR_OFF 12'h104
`define BUSDATA_OFF 12'h108
`define STATUS_OFF 12'h10c
`define AUX_STROBE_OFF_BIT 0
`define AUX_RESET_OUT_DISABLE_BIT 3
`define AUX_CONTROL_RESET 8'h00
`define PORT_RESET 8'hff
`define OSC_PER_MACHINE_CYCLE 4'd12
`define RESET_IN_MACHINE_CYCLES 5'd2
`define RESET_OUT_OSC_PERIODS 7'd98
`endif

// file: src/xbus_pkg.sv
// Purpose: Types shared by the external bus pin control.
// Assumes: Nothing beyond the defs header.
// Notes: States of the bus sequencer.
package xbus_pkg;
  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_RUN} acc_state_t;
endpackage

// file: src/pin_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of pins.
// Assumes: Pins are asynchronous to pclk.
// Notes: First stage is read only by the second.
`timescale 1ns/1ps
module pin_sync #(parameter int W = 8) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pins and synchronised copy.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Next values of both stages.
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  // Register both stages.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pin_sync_out = sync_r;
endmodule // pin_sync

// file: src/watchdog_reset.sv
// Purpose: Reset input filter and watchdog reset-out pulse.
// Assumes: reset_pin_sync already passed a synchroniser.
// Notes: Reset-out drive is suppressed when disabled.
`timescale 1ns/1ps
`include "xbus_defs.svh"
module watchdog_reset (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Phase and control.
  input wire logic machine_tick,
  input wire logic reset_out_disable,
  input wire logic watchdog_timeout,
  input wire logic reset_pin_sync,
  // Results.
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic device_reset
);
  logic [4:0] hold_r;
  logic [4:0] hold_nxt;
  logic [6:0] out_r;
  logic [6:0] out_nxt;
  logic rst_r;
  logic rst_nxt;

  // Count machine cycles of high reset input, and the reset-out pulse; own drive is not counted as input.
  always_comb begin
    hold_nxt = hold_r;
    rst_nxt = rst_r;
    out_nxt = out_r;
    if (!reset_pin_sync || out_r != 7'd0) begin
      hold_nxt = 5'd0;
      rst_nxt = 1'b0;
    end else if (machine_tick) begin
      if (hold_r >= `RESET_IN_MACHINE_CYCLES - 5'd1) begin
        rst_nxt = 1'b1;
      end else begin
        hold_nxt = hold_r + 5'd1;
      end
    end
    if (out_r != 7'd0) begin
      out_nxt = out_r - 7'd1;
    end else if (watchdog_timeout && !reset_out_disable) begin
      out_nxt = `RESET_OUT_OSC_PERIODS;
    end
  end

  // Register the counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 5'd0;
      out_r <= 7'd0;
      rst_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      out_r <= out_nxt;
      rst_r <= rst_nxt;
    end
  end

  assign reset_pin_o = 1'b1;
  assign reset_pin_oe = (out_r != 7'd0);
  assign device_reset = rst_r;
endmodule // watchdog_reset

// file: src/xbus_pin_ctrl.sv
// Purpose: Pin control of the multiplexed external memory bus, reset pin and port alternate functions.
// Assumes: pclk is the oscillator; APB gives access to the special function registers.
// Notes: Each port pin is output, output enable and input; weak pull-ups are shown on pullup outputs.
`timescale 1ns/1ps
`include "xbus_defs.svh"
module xbus_pin_ctrl
  import xbus_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side.
  input wire logic watchdog_timeout,
  input wire logic lock_bit1_programmed,
  input wire logic timer2_clock_out_en,
  input wire logic timer2_clock_out,
  input wire logic serial_tx,
  output logic device_reset,
  output logic timer2_count_input,
  output logic timer2_trigger_input,
  output logic serial_rx,
  output logic external_interrupt_zero,
  output logic external_interrupt_one,
  output logic timer0_input,
  output logic timer1_input,
  // Reset pin.
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  // Strobes and strap.
  output logic addr_latch_strobe,
  output logic addr_latch_weak_pullup,
  output logic program_read_strobe_n,
  input wire logic external_access_select_n,
  // Ports.
  input wire logic [7:0] low_address_data_port_i,
  output logic [7:0] low_address_data_port_o,
  output logic [7:0] low_address_data_port_oe,
  output logic low_address_data_port_pullup,
  input wire logic [7:0] high_address_port_i,
  output logic [7:0] high_address_port_o,
  output logic [7:0] high_address_port_oe,
  input wire logic [7:0] port1_i,
  output logic [7:0] port1_o,
  output logic [7:0] port1_oe,
  input wire logic [7:0] port3_i,
  output logic [7:0] port3_o,
  output logic [7:0] port3_oe
);
  // Port output registers, aux control and the bus access registers, each with its next value.
  logic [7:0] aux_r, aux_nxt, p0_r, p0_nxt, p1_r, p1_nxt, p2_r, p2_nxt, p3_r, p3_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [2:0] req_r, req_nxt;
  logic [3:0] phase_r, phase_nxt;
  logic mc_r, mc_nxt;
  logic ea_r, ea_nxt;
  logic [1:0] ea_taken_r, ea_taken_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  acc_state_t st_r, st_nxt;
  // Synchronised pin copies and decoded phase qualifiers.
  logic [7:0] p0_s, p1_s, p2_s, p3_s;
  logic [1:0] misc_s;
  logic ext_exec, wr_en, data_cycle, data_addr_phase;
  logic ale_raw, program_read_strobe_raw;

  // Synchronise every pin input before use.
  pin_sync #(.W(8)) u_sync0 (.pclk(pclk), .presetn(presetn), .pin_in(low_address_data_port_i), .pin_sync_out(p0_s));
  pin_sync #(.W(8)) u_sync1 (.pclk(pclk), .presetn(presetn), .pin_in(port1_i), .pin_sync_out(p1_s));
  pin_sync #(.W(8)) u_sync2 (.pclk(pclk), .presetn(presetn), .pin_in(high_address_port_i), .pin_sync_out(p2_s));
  pin_sync #(.W(8)) u_sync3 (.pclk(pclk), .presetn(presetn), .pin_in(port3_i), .pin_sync_out(p3_s));
  // Reset pin and strap share one two-bit synchroniser.
  pin_sync #(.W(2)) u_syncm (.pclk(pclk), .presetn(presetn),
    .pin_in({reset_pin_i, external_access_select_n}), .pin_sync_out(misc_s));

  // Reset input filter and watchdog reset-out.
  watchdog_reset u_wdr (
    .pclk(pclk),
    .presetn(presetn),
    .machine_tick(mc_r),
    .reset_out_disable(aux_r[`AUX_RESET_OUT_DISABLE_BIT]),
    .watchdog_timeout(watchdog_timeout),
    .reset_pin_sync(misc_s[1]),
    .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe),
    .device_reset(device_reset)
  );

  // Decode an APB byte address to its register.
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    case (a)
      `PORT0_OFF: reg_sel = 4'd1;
      `PORT1_OFF: reg_sel = 4'd2;
      `PORT2_OFF: reg_sel = 4'd3;
      `PORT3_OFF: reg_sel = 4'd4;
      `AUX_CONTROL_OFF: reg_sel = 4'd5;
      `BUSREQ_OFF: reg_sel = 4'd6;
      `BUSADDR_OFF: reg_sel = 4'd7;
      `BUSDATA_OFF: reg_sel = 4'd8;
      `STATUS_OFF: reg_sel = 4'd9;
      default: reg_sel = 4'd0;
    endcase
  endfunction

  // APB answers at once: writes land in the access phase, read data was captured in the setup cycle.
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (reg_sel(paddr) == 4'd0);
  assign prdata = rdata_r;
  assign ext_exec = ea_r;

  // Oscillator phase in a twelve period machine cycle, and the access sequencer.
  always_comb begin
    phase_nxt = (phase_r == `OSC_PER_MACHINE_CYCLE - 4'd1) ? 4'd0 : phase_r + 4'd1;
    mc_nxt = (phase_r == `OSC_PER_MACHINE_CYCLE - 4'd1);
    st_nxt = st_r;
    req_nxt = req_r;
    case (st_r)
      ACC_IDLE: if (req_r[0]) st_nxt = ACC_WAIT;
      // Switching on the last phase makes the access cycle run from phase 0 to phase 11.
      ACC_WAIT: if (mc_nxt) st_nxt = ACC_RUN;
      ACC_RUN: if (mc_nxt) begin
        st_nxt = ACC_IDLE;
        req_nxt[0] = 1'b0;
      end
      default: st_nxt = ACC_IDLE;
    endcase
    if (wr_en && reg_sel(paddr) == 4'd6) req_nxt = pwdata[2:0];
  end

  // A data access occupies one whole machine cycle.
  assign data_cycle = (st_r == ACC_RUN);
  assign data_addr_phase = data_cycle && (phase_r < 4'd6);

  // Strobe timing: the latch strobe on phases 0 and 6, program read in the following phases.
  // Program reads fill phases 2 to 5 and 10 to 11; a data cycle skips both of them.
  always_comb begin
    ale_raw = (phase_r == 4'd0 || phase_r == 4'd6);
    if (data_cycle && phase_r == 4'd6) ale_raw = 1'b0;
    program_read_strobe_raw = ext_exec && !data_cycle && (phase_r[2:0] >= 3'd2) && (phase_r != 4'd6) && (phase_r != 4'd7);
  end

  // With suppression the strobe is held low and the pin is left to its weak pull-up; program execution overrides.
  // Data cycles always keep their address strobe, so an external latch never misses an address.
  assign addr_latch_strobe = (aux_r[`AUX_STROBE_OFF_BIT] && !ext_exec && !data_cycle) ? 1'b0 : ale_raw;
  assign addr_latch_weak_pullup = aux_r[`AUX_STROBE_OFF_BIT] && !ext_exec && !data_cycle;
  assign program_read_strobe_n = !program_read_strobe_raw;

  // Register writes, the strap latch and captured read data.
  always_comb begin
    aux_nxt = aux_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    p3_nxt = p3_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    ea_nxt = ea_r;
    ea_taken_nxt = ea_taken_r;
    if (wr_en) begin
      case (reg_sel(paddr))
        4'd1: p0_nxt = pwdata[7:0];
        4'd2: p1_nxt = pwdata[7:0];
        4'd3: p2_nxt = pwdata[7:0];
        4'd4: p3_nxt = pwdata[7:0];
        4'd5: aux_nxt = pwdata[7:0];
        4'd7: addr_nxt = pwdata[15:0];
        4'd8: data_nxt = pwdata[7:0];
        default: aux_nxt = aux_r;
      endcase
    end
    if (data_cycle && !req_r[1] && phase_r == 4'd11) data_nxt = p0_s;
    // The strap is read only once the synchroniser holds a real pin sample, two edges after release.
    // With lock bit 1 it is taken once and then kept; without it the pin is followed.
    if (ea_taken_r == 2'd2 || (ea_taken_r == 2'd3 && !lock_bit1_programmed)) begin
      ea_nxt = !misc_s[0];
    end
    if (ea_taken_r != 2'd3) begin
      ea_taken_nxt = ea_taken_r + 2'd1;
    end
    case (reg_sel(paddr))
      4'd1: rdata_nxt = {24'h000000, p0_s};
      4'd2: rdata_nxt = {24'h000000, p1_s};
      4'd3: rdata_nxt = {24'h000000, p2_s};
      4'd4: rdata_nxt = {24'h000000, p3_s};
      4'd5: rdata_nxt = {24'h000000, aux_r};
      4'd6: rdata_nxt = {29'h00000000, req_r};
      4'd7: rdata_nxt = {16'h0000, addr_r};
      4'd8: rdata_nxt = {24'h000000, data_r};
      4'd9: rdata_nxt = {28'h0000000, ext_exec, data_cycle, st_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Register all control state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_r <= `AUX_CONTROL_RESET;
      p0_r <= `PORT_RESET;
      p1_r <= `PORT_RESET;
      p2_r <= `PORT_RESET;
      p3_r <= `PORT_RESET;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      req_r <= 3'h0;
      phase_r <= 4'h0;
      mc_r <= 1'b0;
      ea_r <= 1'b0;
      ea_taken_r <= 2'd0;
      rdata_r <= 32'h00000000;
      st_r <= ACC_IDLE;
    end else begin
      aux_r <= aux_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      p3_r <= p3_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      req_r <= req_nxt;
      phase_r <= phase_nxt;
      mc_r <= mc_nxt;
      ea_r <= ea_nxt;
      ea_taken_r <= ea_taken_nxt;
      rdata_r <= rdata_nxt;
      st_r <= st_nxt;
    end
  end

  // Low port: address then data in a data cycle; released during program execution; otherwise open drain from its register.
  always_comb begin
    low_address_data_port_pullup = data_cycle || ext_exec;
    if (data_addr_phase) begin
      low_address_data_port_o = addr_r[7:0];
      low_address_data_port_oe = 8'hff;
    end else if (data_cycle) begin
      low_address_data_port_o = data_r;
      low_address_data_port_oe = req_r[1] ? 8'hff : 8'h00;
    end else if (ext_exec) begin
      low_address_data_port_o = 8'h00;
      low_address_data_port_oe = 8'h00;
    end else begin
      low_address_data_port_o = 8'h00;
      low_address_data_port_oe = ~p0_r;
    end
  end

  // High port: address byte strongly driven, or the port register.
  always_comb begin
    if (data_cycle && req_r[2]) begin
      high_address_port_o = addr_r[15:8];
      high_address_port_oe = 8'hff;
    end else begin
      // An eight-bit data access leaves the port register on the pins.
      high_address_port_o = p2_r;
      high_address_port_oe = ~p2_r;
    end
  end

  // Port 1 and port 3 with alternate functions; ones release the pin to its pull-up.
  always_comb begin
    port1_o = p1_r & {7'h7f, ~(timer2_clock_out_en & ~timer2_clock_out)};
    port1_oe = ~port1_o;
    port3_o = p3_r & {~(data_cycle && !req_r[1] && phase_r >= 4'd7), ~(data_cycle && req_r[1] && phase_r >= 4'd7),
      6'h3f} & {6'h3f, serial_tx, 1'b1};
    port3_oe = ~port3_o;
  end

  // Alternate inputs read the synchronised pins.
  assign timer2_count_input = p1_s[0];
  assign timer2_trigger_input = p1_s[1];
  assign serial_rx = p3_s[0];
  assign external_interrupt_zero = p3_s[2];
  assign external_interrupt_one = p3_s[3];
  assign timer0_input = p3_s[4];
  assign timer1_input = p3_s[5];
endmodule // xbus_pin_ctrl

// file: test/xbus_pin_ctrl_properties.sv
// Purpose: Checks on strobes, reset pin and low port drive.
// Assumes: One oscillator period per pclk cycle.
// Notes: Bound into xbus_pin_ctrl.
`timescale 1ns/1ps
module xbus_pin_ctrl_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Reset pin.
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic device_reset,
  // Strobes and ports.
  input wire logic addr_latch_strobe,
  input wire logic addr_latch_weak_pullup,
  input wire logic program_read_strobe_n,
  input wire logic [7:0] low_address_data_port_oe,
  input wire logic [7:0] port3_o,
  input wire logic [7:0] port3_oe
);
  logic [6:0] oe_cnt_r, oe_cnt_nxt;
  logic [7:0] hi_cnt_r, hi_cnt_nxt;
  logic run_r;
  logic ale_pin;
  default clocking @(posedge pclk); endclocking
  // Attempts on the release edge still see the strobe of the held phase, so they are dropped too.
  default disable iff (!presetn || !run_r);
  // Level of the latch strobe pin: driven high or left to its weak pull-up.
  assign ale_pin = addr_latch_strobe | addr_latch_weak_pullup;
  // Lengths of the reset drive run and of the high pin run; the second saturates.
  always_comb begin
    oe_cnt_nxt = reset_pin_oe ? oe_cnt_r + 7'h01 : 7'h00;
    hi_cnt_nxt = !reset_pin_i ? 8'h00 : (hi_cnt_r == 8'hff) ? hi_cnt_r : hi_cnt_r + 8'h01;
  end
  // Registers the run counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt_r <= 7'h00;
      hi_cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else begin
      oe_cnt_r <= oe_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      run_r <= 1'b1;
    end
  end
  property p_ale_pulse; addr_latch_strobe |=> !addr_latch_strobe; endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too wide");
  property p_ale_rate;
    addr_latch_strobe |-> ##6 (addr_latch_strobe || addr_latch_weak_pullup) or ##7 (port3_o[7:6] != 2'b11);
  endproperty
  a_ale_rate: assert property (p_ale_rate) else $error("latch strobe rate wrong");
  property p_ale_weak; addr_latch_weak_pullup |-> !addr_latch_strobe; endproperty
  a_ale_weak: assert property (p_ale_weak) else $error("strobe while held weak");
  property p_prs_phase;
    !program_read_strobe_n |-> $past(ale_pin, 2) || $past(ale_pin, 3) || $past(ale_pin, 4) || $past(ale_pin, 5);
  endproperty
  a_prs_phase: assert property (p_prs_phase) else $error("program strobe off phase");
  property p_rst_len; $fell(reset_pin_oe) |-> oe_cnt_r == 7'd98; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset drive length wrong");
  property p_rst_lvl; reset_pin_oe |-> reset_pin_o; endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset driven low");
  property p_wr_drive; port3_oe[6] && !port3_o[6] |-> low_address_data_port_oe == 8'hff; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("low port not driven in write");
  property p_dev_rst; $rose(device_reset) |-> hi_cnt_r >= 8'd13; endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("device reset too early");
endmodule // xbus_pin_ctrl_chk
bind xbus_pin_ctrl xbus_pin_ctrl_chk chk (.pclk, .presetn, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .device_reset,
  .addr_latch_strobe, .addr_latch_weak_pullup, .program_read_strobe_n, .low_address_data_port_oe, .port3_o, .port3_oe);

// file: test/ext_mem_model.sv
// Purpose: External data memory behind an address latch.
// Assumes: The bench resolves the wire levels.
// Notes: Drives the low port only while the read strobe is low.
`timescale 1ns/1ps
module ext_mem_model (
  // Pins.
  input wire logic pclk,
  input wire logic ale,
  input wire logic [7:0] ad,
  input wire logic [7:0] ah,
  input wire logic wr_n,
  input wire logic rd_n,
  // Low port drive.
  output logic [7:0] ad_o,
  output logic ad_oe
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_r;
  logic [15:0] last_addr;
  // The latch follows the low port while the strobe is high; writes land while the write strobe is low.
  always @(posedge pclk) begin
    if (ale) lat_r <= ad;
    if (!wr_n) mem[{ah, lat_r}] <= ad;
    if (!wr_n || !rd_n) last_addr <= {ah, lat_r};
  end
  // Read data is driven only during the read strobe.
  assign ad_o = mem[{ah, lat_r}];
  assign ad_oe = !rd_n;
endmodule // ext_mem_model

// file: test/testbench.sv
// Purpose: Self-checking bench of the external bus pin control.
// Assumes: APB master on pclk, ports resolved with pull-ups.
// Notes: Random values come from an LFSR.
`timescale 1ns/1ps
`include "xbus_defs.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_timeout, lock_bit1_programmed;
  logic timer2_clock_out_en, timer2_clock_out, serial_tx, device_reset, timer2_count_input, timer2_trigger_input;
  logic serial_rx, external_interrupt_zero, external_interrupt_one, timer0_input, timer1_input, reset_pin_i;
  logic reset_pin_o, reset_pin_oe, addr_latch_strobe, addr_latch_weak_pullup, program_read_strobe_n;
  logic external_access_select_n, low_address_data_port_pullup, rst_drv, moe, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, seed;
  logic [7:0] low_address_data_port_i, low_address_data_port_o, low_address_data_port_oe, high_address_port_i;
  logic [7:0] high_address_port_o, high_address_port_oe, port1_i, port1_o, port1_oe, port3_i, port3_o, port3_oe;
  logic [7:0] p1b, p3b, md, p0last;
  int n_mismatch, checks, na, np, nr, nd;
  // Wire levels: driven bits win; released lines read p1b, p3b or rst_drv, the high port pulls high;
  // the low port reads md while the memory drives, else pulls high under its pull-up, else floats to the inverse of its last level.
  assign reset_pin_i = reset_pin_oe ? reset_pin_o : rst_drv;
  assign low_address_data_port_i = (low_address_data_port_oe & low_address_data_port_o) |
    (~low_address_data_port_oe & (moe ? md : (low_address_data_port_pullup ? 8'hff : ~p0last)));
  assign high_address_port_i = high_address_port_o | ~high_address_port_oe;
  assign port1_i = (port1_oe & port1_o) | (~port1_oe & p1b);
  assign port3_i = (port3_oe & port3_o) | (~port3_oe & p3b);
  always @(posedge pclk) p0last <= low_address_data_port_i;
  xbus_pin_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .watchdog_timeout, .lock_bit1_programmed, .timer2_clock_out_en, .timer2_clock_out, .serial_tx, .device_reset,
    .timer2_count_input, .timer2_trigger_input, .serial_rx, .external_interrupt_zero, .external_interrupt_one,
    .timer0_input, .timer1_input, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .addr_latch_strobe,
    .addr_latch_weak_pullup, .program_read_strobe_n, .external_access_select_n, .low_address_data_port_i,
    .low_address_data_port_o, .low_address_data_port_oe, .low_address_data_port_pullup, .high_address_port_i,
    .high_address_port_o, .high_address_port_oe, .port1_i, .port1_o, .port1_oe, .port3_i, .port3_o, .port3_oe);
  ext_mem_model u_mem (.pclk, .ale(addr_latch_strobe | addr_latch_weak_pullup), .ad(low_address_data_port_i),
    .ah(high_address_port_i), .wr_n(port3_i[6]), .rd_n(port3_i[7]), .ad_o(md), .ad_oe(moe));
  // Clock of 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] released(input logic [7:0] v);
    return {24'h0, ~v};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Starts an external access and polls until the sequencer is idle.
  task automatic xfer(input logic [2:0] req, input logic [15:0] a, input logic [7:0] d);
    int k = 0;
    apb(1'b1, `BUSADDR_OFF, {16'h0, a});
    apb(1'b1, `BUSDATA_OFF, {24'h0, d});
    apb(1'b1, `BUSREQ_OFF, {29'h0, req});
    repeat (2) @(posedge pclk);
    do begin
      apb(1'b0, `STATUS_OFF, 32'h0);
      k++;
    end while (rdata[1:0] != 2'b00 && k < 40);
    chk("access done", 32'(rdata[1:0]), 32'h0);
  endtask
  // Counts strobes, program strobe falls, reset drive and device reset over n cycles.
  task automatic count(input int n);
    logic pv = program_read_strobe_n;
    {na, np, nr, nd} = 128'h0;
    repeat (n) begin
      @(posedge pclk);
      na += addr_latch_strobe;
      np += pv && !program_read_strobe_n;
      nr += reset_pin_oe;
      nd += device_reset;
      pv = program_read_strobe_n;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
  // Main sequence.
  initial begin
    {seed, n_mismatch, checks, p0last} = {32'd92176, 64'h0, 8'h00};
    {psel, penable, pwrite, watchdog_timeout, lock_bit1_programmed, rst_drv} = 6'h0;
    {timer2_clock_out_en, timer2_clock_out, serial_tx, external_access_select_n} = 4'h1;
    {paddr, pwdata, p1b, p3b, presetn} = {44'h0, 16'hffff, 1'b0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `AUX_CONTROL_OFF, 32'h0);
    chk("aux reset", rdata, 32'h0);
    apb(1'b0, 12'h1f0, 32'h0);
    chk("unmapped error", 32'(serr), 32'h1);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      apb(1'b1, `PORT0_OFF + 12'(i) * 12'h040, seed);
      @(posedge pclk);
      chk("port oe", {24'h0, i == 0 ? low_address_data_port_oe : i == 1 ? port1_oe : high_address_port_oe},
        released(seed[7:0]));
      apb(1'b1, `PORT0_OFF + 12'(i) * 12'h040, 32'hff);
    end
    chk("low port float", 32'(low_address_data_port_pullup), 32'h0);
    seed = lfsr(seed);
    p1b <= seed[7:0];
    p3b <= {2'b11, seed[13:8]};
    repeat (4) @(posedge pclk);
    chk("p3 alt", {timer1_input, timer0_input, external_interrupt_one, external_interrupt_zero, serial_rx},
      {p3b[5:2], p3b[0]});
    chk("p1 alt", {timer2_trigger_input, timer2_count_input}, p1b[1:0]);
    {timer2_clock_out_en, serial_tx} <= 2'b11;
    @(posedge pclk);
    chk("t2 clock out", 32'(port1_o[0]), 32'h0);
    chk("serial tx", 32'(port3_o[1]), 32'h1);
    timer2_clock_out_en <= 1'b0;
    apb(1'b0, `PORT3_OFF, 32'h0);
    chk("p3 read", {rdata[7:2], rdata[0]}, {p3b[7:2], p3b[0]});
    count(24);
    chk("ale internal", na, 4);
    chk("program_read_strobe internal", np, 0);
    apb(1'b1, `AUX_CONTROL_OFF, 32'h1);
    count(24);
    chk("ale suppressed", na, 0);
    chk("weak high", 32'(addr_latch_weak_pullup), 32'h1);
    external_access_select_n <= 1'b0;
    repeat (6) @(posedge pclk);
    count(24);
    chk("ale external", na, 4);
    chk("program_read_strobe external", np, 4);
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("ext exec", 32'(rdata[3]), 32'h1);
    apb(1'b1, `AUX_CONTROL_OFF, 32'h0);
    seed = lfsr(seed);
    xfer(3'b111, seed[15:0], seed[23:16]);
    chk("addr16", 32'(u_mem.last_addr), 32'(seed[15:0]));
    apb(1'b1, `PORT2_OFF, {24'h0, ~seed[15:8]});
    xfer(3'b011, {8'h00, seed[7:0]}, ~seed[23:16]);
    chk("addr8", 32'(u_mem.last_addr), {16'h0, ~seed[15:8], seed[7:0]});
    apb(1'b1, `PORT2_OFF, 32'hff);
    xfer(3'b101, seed[15:0], 8'h00);
    apb(1'b0, `BUSDATA_OFF, 32'h0);
    chk("read16", rdata, {24'h0, seed[23:16]});
    external_access_select_n <= 1'b1;
    apb(1'b1, `AUX_CONTROL_OFF, 32'h1);
    xfer(3'b101, {~seed[15:8], seed[7:0]}, 8'h00);
    apb(1'b0, `BUSDATA_OFF, 32'h0);
    chk("read suppressed", rdata, {24'h0, ~seed[23:16]});
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("internal exec", 32'(rdata[3]), 32'h0);
    apb(1'b1, `AUX_CONTROL_OFF, 32'h0);
    @(posedge pclk) watchdog_timeout <= 1'b1;
    @(posedge pclk) watchdog_timeout <= 1'b0;
    count(120);
    chk("reset out", nr, 98);
    repeat (40) @(posedge pclk);
    apb(1'b1, `AUX_CONTROL_OFF, 32'h8);
    @(posedge pclk) watchdog_timeout <= 1'b1;
    @(posedge pclk) watchdog_timeout <= 1'b0;
    count(120);
    chk("reset out off", nr, 0);
    rst_drv <= 1'b1;
    count(8);
    chk("short reset", nd, 0);
    count(48);
    rst_drv <= 1'b0;
    chk("long reset", 32'(nd != 0), 32'h1);
    lock_bit1_programmed <= 1'b1;
    external_access_select_n <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    external_access_select_n <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("strap latched", 32'(rdata[3]), 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    external_access_select_n <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, `STATUS_OFF, 32'h0);
    chk("strap held high", 32'(rdata[3]), 32'h0);
    print_verdict;
  end
endmodule // testbench
